// ==== core/gfc_pkg.sv ====
// Package for the gated frequency counter: register map, fields, timing constants
package gfc_pkg;
    localparam int unsigned CNT_W       = 32;
    localparam int unsigned GATE_W      = 32;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned REF_MHZ     = 10;
    localparam int unsigned CLK_MHZ     = 200;
    // System cycles per reference half period, for the internal reference divider
    localparam int unsigned REF_HALF    = CLK_MHZ / (2 * REF_MHZ);
    localparam int unsigned DIV_W       = 8;
    localparam logic [DIV_W-1:0] REF_HALF_M1 = DIV_W'(REF_HALF - 1);

    localparam logic [ADDR_W-1:0] A_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] A_GATE   = 8'h04;
    localparam logic [ADDR_W-1:0] A_CMD    = 8'h08;
    localparam logic [ADDR_W-1:0] A_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] A_COUNT  = 8'h10;

    // Control register fields
    localparam int unsigned F_BAND     = 0;   // 2 bits
    localparam int unsigned F_EXTREF   = 2;
    localparam int unsigned F_FREERUN  = 3;
    localparam int unsigned F_MULT     = 4;   // 2 bits
    // Command register fields (write-only pulses)
    localparam int unsigned F_CLEAR    = 0;
    localparam int unsigned F_START    = 1;
    // Status register fields
    localparam int unsigned F_DONE     = 0;
    localparam int unsigned F_OVF      = 1;
    localparam int unsigned F_BUSY     = 2;
    localparam int unsigned F_CMP      = 3;

    localparam logic [GATE_W-1:0] GATE_RST = 32'h0000_2710;

    typedef enum logic [1:0] {
        GFC_MUL_PASS   = 2'b00,
        GFC_MUL_DOUBLE = 2'b01,
        GFC_MUL_BIAS   = 2'b10
    } gfc_mult_t;

    // Declared MSB first so that each field lands on its control register bit position
    typedef struct packed {
        gfc_mult_t  mult;
        logic       free_run;
        logic       ext_ref;
        logic [1:0] band;
    } gfc_ctrl_t;

    typedef struct packed {
        logic       osc_pass;
        logic       osc_double;
        logic       bias_only;
    } gfc_mult_out_t;
endpackage

// ==== core/gfc_sync.sv ====
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module gfc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule // gfc_sync

// ==== core/gfc_counter.sv ====
// Gated frequency counter core with APB register slave
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module gfc_counter (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        ext_ref_i,
    input  wire logic [2:0]  band_in_i,
    input  wire logic        amp_cmp_i,
    output logic      [1:0]  band_sel_o,
    output logic             osc_pass_o,
    output logic             osc_double_o,
    output logic             osc_bias_only_o,
    output logic             gate_o
);
    typedef enum logic [1:0] {
        GFC_IDLE = 2'b00,
        GFC_ARM  = 2'b01,
        GFC_OPEN = 2'b10
    } gfc_state_t;

    logic [4:0] pins_s;
    gfc_sync #(.W(5)) u_sync (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .async_i   ({amp_cmp_i, band_in_i, ext_ref_i}),
        .sync_o    (pins_s)
    );
    logic       ext_ref_s;
    logic [2:0] band_s;
    logic       cmp_s;
    assign ext_ref_s = pins_s[0];
    assign band_s    = pins_s[3:1];
    assign cmp_s     = pins_s[4];

    // Registers
    gfc_pkg::gfc_ctrl_t       ctrl_q, ctrl_d;
    logic [gfc_pkg::GATE_W-1:0] gate_len_q, gate_len_d;
    logic [gfc_pkg::CNT_W-1:0]  count_q, count_d;
    logic [gfc_pkg::GATE_W-1:0] gate_cnt_q, gate_cnt_d;
    logic [gfc_pkg::DIV_W-1:0]  div_q, div_d;
    logic                       iref_q, iref_d;
    logic                       ref_prev_q, ref_prev_d;
    logic                       in_prev_q, in_prev_d;
    logic                       done_q, done_d;
    logic                       ovf_q, ovf_d;
    logic                       cmp_q, cmp_d;
    logic [31:0]                prdata_q, prdata_d;
    gfc_state_t                 st_q, st_d;

    logic wr_acc;
    logic rd_acc;
    logic cmd_clear;
    logic cmd_start;
    logic ref_lvl;
    logic ref_edge;
    logic in_sel;
    logic in_edge;
    logic addr_ok;

    assign wr_acc    = psel && penable && pwrite;
    assign rd_acc    = psel && !penable && !pwrite;
    assign cmd_clear = wr_acc && (paddr == gfc_pkg::A_CMD) && pwdata[gfc_pkg::F_CLEAR];
    assign cmd_start = wr_acc && (paddr == gfc_pkg::A_CMD) && pwdata[gfc_pkg::F_START];
    assign addr_ok   = (paddr == gfc_pkg::A_CTRL) || (paddr == gfc_pkg::A_GATE) ||
                       (paddr == gfc_pkg::A_CMD) || (paddr == gfc_pkg::A_STATUS) ||
                       (paddr == gfc_pkg::A_COUNT);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_ok;
    assign prdata    = prdata_q;

    // Timebase: internal divider or synchronised external reference
    assign ref_lvl  = ctrl_q.ext_ref ? ext_ref_s : iref_q;
    assign ref_edge = ref_lvl && !ref_prev_q;
    assign in_sel   = band_s[ctrl_q.band];
    assign in_edge  = in_sel && !in_prev_q;

    always_comb begin
        ctrl_d     = ctrl_q;
        gate_len_d = gate_len_q;
        div_d      = div_q;
        iref_d     = iref_q;
        if (div_q == gfc_pkg::REF_HALF_M1) begin
            div_d  = '0;
            iref_d = !iref_q;
        end else begin
            div_d = div_q + 1'b1;
        end
        ref_prev_d = ref_lvl;
        in_prev_d  = in_sel;
        cmp_d      = cmp_s;
        if (wr_acc && paddr == gfc_pkg::A_CTRL) begin
            ctrl_d = gfc_pkg::gfc_ctrl_t'(pwdata[5:0]);
        end
        if (wr_acc && paddr == gfc_pkg::A_GATE && pwdata != '0) begin
            gate_len_d = pwdata;
        end
        prdata_d = '0;
        if (rd_acc) begin
            unique case (paddr)
                gfc_pkg::A_CTRL:   prdata_d = {26'h0, ctrl_q};
                gfc_pkg::A_GATE:   prdata_d = gate_len_q;
                gfc_pkg::A_STATUS: prdata_d = {28'h0, cmp_q, (st_q != GFC_IDLE), ovf_q, done_q};
                gfc_pkg::A_COUNT:  prdata_d = count_q;
                default:           prdata_d = '0;
            endcase
        end else begin
            prdata_d = prdata_q;
        end
    end

    // Gate sequencer
    always_comb begin
        st_d       = st_q;
        gate_cnt_d = gate_cnt_q;
        count_d    = count_q;
        done_d     = done_q;
        ovf_d      = ovf_q;
        unique case (st_q)
            GFC_IDLE: begin
                if (cmd_start) begin
                    st_d = GFC_ARM;
                end
            end
            GFC_ARM: begin
                if (ref_edge) begin
                    st_d       = GFC_OPEN;
                    gate_cnt_d = gate_len_q;
                end
            end
            GFC_OPEN: begin
                if (in_edge) begin
                    count_d = count_q + 1'b1;
                    if (&count_q) begin
                        ovf_d = 1'b1;
                    end
                end
                if (ref_edge) begin
                    if (gate_cnt_q == 32'h0000_0001) begin
                        done_d = 1'b1;
                        st_d   = ctrl_q.free_run ? GFC_ARM : GFC_IDLE;
                    end else begin
                        gate_cnt_d = gate_cnt_q - 1'b1;
                    end
                end
            end
            default: st_d = GFC_IDLE;
        endcase
        // Free run restarts accumulation at each new gate that opens while done is still set
        if (st_q == GFC_ARM && ref_edge && ctrl_q.free_run && done_q) begin
            count_d = '0;
            done_d  = 1'b0;
        end
        if (cmd_clear) begin
            count_d = '0;
            done_d  = 1'b0;
            ovf_d   = 1'b0;
            st_d    = GFC_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl_q     <= '0;
            gate_len_q <= gfc_pkg::GATE_RST;
            div_q      <= '0;
            iref_q     <= 1'b0;
            ref_prev_q <= 1'b0;
            in_prev_q  <= 1'b0;
            cmp_q      <= 1'b0;
            prdata_q   <= '0;
            st_q       <= GFC_IDLE;
            gate_cnt_q <= '0;
            count_q    <= '0;
            done_q     <= 1'b0;
            ovf_q      <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            gate_len_q <= gate_len_d;
            div_q      <= div_d;
            iref_q     <= iref_d;
            ref_prev_q <= ref_prev_d;
            in_prev_q  <= in_prev_d;
            cmp_q      <= cmp_d;
            prdata_q   <= prdata_d;
            st_q       <= st_d;
            gate_cnt_q <= gate_cnt_d;
            count_q    <= count_d;
            done_q     <= done_d;
            ovf_q      <= ovf_d;
        end
    end

    // Multiplier and band decode from the control register; gate from the sequencer state
    assign band_sel_o      = ctrl_q.band;
    assign osc_pass_o      = (ctrl_q.mult == gfc_pkg::GFC_MUL_PASS);
    assign osc_double_o    = (ctrl_q.mult == gfc_pkg::GFC_MUL_DOUBLE);
    assign osc_bias_only_o = (ctrl_q.mult == gfc_pkg::GFC_MUL_BIAS);
    assign gate_o          = (st_q == GFC_OPEN);

    gate_idle_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (st_q == GFC_IDLE && !cmd_start) |=> st_q != GFC_OPEN)
        else $error("gate opened without start");
    count_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (st_q == GFC_IDLE && !cmd_clear) |=> $stable(count_q))
        else $error("count moved while gate closed");
    done_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (st_q == GFC_OPEN && ref_edge && gate_cnt_q == 32'h1 && !cmd_clear) |=> done_q)
        else $error("done not set at gate close");
    clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cmd_clear |=> (count_q == '0 && !done_q && !ovf_q))
        else $error("clear did not zero counter");
    ovf_sticky_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (ovf_q && !cmd_clear) |=> ovf_q)
        else $error("overflow flag lost");
    cmp_track_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ##1 cmp_q == $past(cmp_s))
        else $error("comparator bit stale");
    mult_onehot_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $onehot0({osc_pass_o, osc_double_o, osc_bias_only_o}))
        else $error("multiplier outputs conflict");
    hold_mode_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (gate_o && ref_edge && gate_cnt_q == 32'h1 && !ctrl_q.free_run && !cmd_clear)
        |=> st_q == GFC_IDLE)
        else $error("single shot did not hold");
endmodule // gfc_counter

// ==== dv/gfc_src.sv ====
// Signal sources for the counter pins: external reference and three band tones
`timescale 1ns/10ps
module gfc_src (
    input  wire logic       clk_sys_i,
    output logic            ext_ref_o,
    output logic      [2:0] band_o
);
    int c = 0;

    // Every period divides 20 cycles, so a gate of whole reference periods sees exact counts
    always @(posedge clk_sys_i) c <= (c == 19) ? 0 : c + 1;
    assign ext_ref_o = (c < 10);
    assign band_o    = {(c >= 3 && c < 13), ((c % 10) < 5), ((c % 4) < 2)};
endmodule // gfc_src

// ==== dv/gfc_counter_tb_top.sv ====
// Self-checking bench for the gated frequency counter
`timescale 1ns/10ps
module gfc_counter_tb_top;
    logic        clk_sys_i, reset_i, psel, penable, pwrite, amp_cmp_i, gq, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, ctrl_m, gate_m;
    logic        pready, pslverr, ext_ref_i, osc_pass_o, osc_double_o, osc_bias_only_o, gate_o;
    logic [2:0]  band_in_i;
    logic [1:0]  band_sel_o;
    int          n_errors = 0, n_checks = 0, ghi = 0, grise = 0, g0, t;
    int          half[3] = '{2, 5, 10};

    gfc_counter i_gfc_counter (.clk_sys_i, .reset_i, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_ref_i, .band_in_i, .amp_cmp_i,
        .band_sel_o, .osc_pass_o, .osc_double_o, .osc_bias_only_o, .gate_o);
    gfc_src i_gfc_src (.clk_sys_i, .ext_ref_o(ext_ref_i), .band_o(band_in_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        gq <= gate_o;
        if (gate_o) ghi <= ghi + 1;
        if (gate_o && !gq) grise <= grise + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One single-shot measurement on band b with a random gate length
    task automatic meas(input int b, input logic ext);
        int gl, f;
        gl = 1 + $urandom % 6;
        ctrl_m = {28'h0, 1'b0, ext, 2'(b)};
        apb(1'b1, gfc_pkg::A_CTRL, ctrl_m);
        apb(1'b1, gfc_pkg::A_GATE, 32'(gl));
        gate_m = 32'(gl);
        apb(1'b1, gfc_pkg::A_CMD, 32'h1);
        g0 = ghi;
        chk(32'(band_sel_o), 32'(b));
        repeat (40) @(posedge clk_sys_i);
        apb(1'b0, gfc_pkg::A_STATUS, 32'h0);
        chk(32'(rd[gfc_pkg::F_DONE]), 32'h0);
        chk(32'(ghi - g0), 32'h0);
        apb(1'b1, gfc_pkg::A_CMD, 32'h2);
        t = 0;
        do begin
            apb(1'b0, gfc_pkg::A_STATUS, 32'h0);
            t++;
        end while (rd[gfc_pkg::F_DONE] !== 1'b1 && t < 300);
        chk(32'(rd[3:0]), 32'h1);
        chk(32'(ghi - g0), 32'(gl * 20));
        apb(1'b0, gfc_pkg::A_COUNT, 32'h0);
        chk(rd, 32'(gl * 10 / half[b]));
        f = rd * gfc_pkg::REF_MHZ / gl;
        chk(32'(f), 32'(gfc_pkg::CLK_MHZ / (2 * half[b])));
        repeat (100) @(posedge clk_sys_i);
        apb(1'b0, gfc_pkg::A_COUNT, 32'h0);
        chk(rd, 32'(gl * 10 / half[b]));
        chk(32'(ghi - g0), 32'(gl * 20));
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys_i);
        n_errors++;
        end_of_test();
    end

    initial begin
        {psel, penable, pwrite, amp_cmp_i} = 4'h0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        reset_i = 1'b1;
        void'($urandom(96982));
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        chk(32'(osc_pass_o), 32'h1);
        apb(1'b0, gfc_pkg::A_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, gfc_pkg::A_GATE, 32'h0);
        chk(rd, gfc_pkg::GATE_RST);
        gate_m = gfc_pkg::GATE_RST;
        apb(1'b0, gfc_pkg::A_STATUS, 32'h0);
        chk(rd, 32'h0);
        for (int m = 0; m < 3; m++) begin
            ctrl_m = 32'(m << gfc_pkg::F_MULT);
            apb(1'b1, gfc_pkg::A_CTRL, ctrl_m);
            apb(1'b0, gfc_pkg::A_CTRL, 32'h0);
            chk(rd, ctrl_m);
            chk(32'({osc_pass_o, osc_double_o, osc_bias_only_o}),
                32'({m == 0, m == 1, m == 2}));
        end
        for (int v = 1; v >= 0; v--) begin
            amp_cmp_i <= 1'(v);
            repeat (4) @(posedge clk_sys_i);
            apb(1'b0, gfc_pkg::A_STATUS, 32'h0);
            chk(32'(rd[gfc_pkg::F_CMP]), 32'(v));
        end
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, gfc_pkg::A_GATE, 32'h0);
        apb(1'b0, gfc_pkg::A_GATE, 32'h0);
        chk(rd, gate_m);
        for (int b = 0; b < 3; b++) meas(b, 1'(b == 2));
        apb(1'b1, gfc_pkg::A_CTRL, 32'h8);
        apb(1'b1, gfc_pkg::A_GATE, 32'h1);
        apb(1'b1, gfc_pkg::A_CMD, 32'h1);
        apb(1'b1, gfc_pkg::A_CMD, 32'h2);
        g0 = grise;
        repeat (200) @(posedge clk_sys_i);
        chk(32'((grise - g0) >= 4), 32'h1);
        // Wait out a done window first, so the count is read early in the next one
        t = 0;
        do begin
            apb(1'b0, gfc_pkg::A_STATUS, 32'h0);
            t++;
        end while (rd[gfc_pkg::F_DONE] !== 1'b0 && t < 300);
        do begin
            apb(1'b0, gfc_pkg::A_STATUS, 32'h0);
            t++;
        end while (rd[gfc_pkg::F_DONE] !== 1'b1 && t < 300);
        apb(1'b0, gfc_pkg::A_COUNT, 32'h0);
        chk(rd, 32'(10 / half[0]));
        end_of_test();
    end
endmodule // gfc_counter_tb_top
